// >>> rtl/voltage_comparator_ctrl.sv
// Control and status logic for two voltage comparators behind an APB slave.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "cmp_defs.svh"

// Operation
// [RULE1] Two comparators behave alike; only comparator 0 can request reset.
// [RULE2] Each comparator gives a clock-latched output and a raw unclocked one.
// [RULE3] Raw output path has no flip-flop, so it works with the clock stopped.
// [RULE4] Separate positive and negative input selects steer the analog muxes.
// [RULE5] A disabled comparator drives its pin outputs low.
// [RULE6] Response-mode field goes to the analog core; slower saves current.
// [RULE7] Control bits 3-2 set positive, bits 1-0 negative hysteresis.
// [RULE8] Positive hysteresis codes: off, 5 mV, 10 mV, 20 mV.
// [RULE9] Negative hysteresis uses the same four codes.
// [RULE10] Falling output sets the falling flag; rising output sets rising flag.
// [RULE11] Edge flags stay set until software writes zero to them; the status register also clears them on a write of one.
// [RULE12] Interrupts can come on rising, falling or both edges.
// [RULE13] Control bit 6 reads the current result, one when plus beats minus.
// [RULE14] Control bit 7 enables the comparator when one, disables when zero.
// [RULE15] Comparator 0 control sits at index 9B and resets to zero.
// [RULE16] Mode bit 5 enables rising, bit 4 falling edge interrupts.
// [RULE17] Two-bit response mode, fastest at 0; mode register resets to 02.
// [RULE18] Input select: negative in bits 6-4, positive in bits 2-0.
// [RULE19] Raw decision passes two synchroniser flops before all clocked uses.
module voltage_comparator_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog core.
  input wire logic [1:0] cmp_raw_in,
  output cmp_pkg::cmp_cfg_s [1:0] cmp_cfg,
  // Pin outputs and system requests.
  output logic [1:0] raw_out,
  output logic [1:0] latched_out,
  output logic irq,
  output logic reset_req
);
  import cmp_pkg::*;

  localparam logic [7:0] CTRL_IDX [2] = '{`CMP_CTRL0_IDX, `CMP_CTRL1_IDX};
  localparam logic [7:0] MODE_IDX [2] = '{`CMP_MODE0_IDX, `CMP_MODE1_IDX};
  localparam logic [7:0] MUX_IDX [2] = '{`CMP_MUX0_IDX, `CMP_MUX1_IDX};
  localparam st_s ST_RST = '{
    md: {2{`CMP_MD_RST}},
    mask: `IRQ_MASK_RST,
    default: '0
  };

  st_s st_r;
  st_s st_nxt;
  logic [7:0] idx;
  logic aligned;
  logic hit;
  logic wr;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [7:0] rd_val;

  // Maps a two-bit hysteresis code onto the analog selection.
  function automatic hyst_e hyst_decode(input logic [1:0] code);
    hyst_e h;
    unique case (code)
      2'h0: h = HYST_OFF;
      2'h1: h = HYST_5MV;
      2'h2: h = HYST_10MV;
      2'h3: h = HYST_20MV;
    endcase
    return h;
  endfunction

  // True when the index names a register of this block.
  function automatic logic is_reg(input logic [7:0] i);
    logic r;
    r = (i == `CMP_STAT_IDX) || (i == `CMP_MASK_IDX) || (i == `CMP_RSRC_IDX);
    for (int n = 0; n < 2; n++)
    begin
      r = r || (i == CTRL_IDX[n]) || (i == MODE_IDX[n]) || (i == MUX_IDX[n]);
    end
    return r;
  endfunction

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign hit = aligned && is_reg(idx);
  assign wr = psel && penable && pwrite && hit;

  // Zero wait states; data for reads is captured in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = st_r.prdata;

  always_comb
  begin
    st_nxt = st_r;
    rd_val = 8'h00;
    rise = 2'h0;
    fall = 2'h0;
    for (int n = 0; n < 2; n++)
    begin
      // Two-flop synchroniser; only the second stage is looked at.
      st_nxt.sync1[n] = cmp_raw_in[n]; // RULE19
      st_nxt.sync2[n] = st_r.sync1[n]; // RULE19

      if (wr && idx == CTRL_IDX[n])
      begin
        st_nxt.en[n] = pwdata[`CTRL_EN_BIT]; // RULE14
        if (!pwdata[`CTRL_RIF_BIT])
        begin
          st_nxt.rif[n] = 1'b0; // RULE11
        end
        if (!pwdata[`CTRL_FIF_BIT])
        begin
          st_nxt.fif[n] = 1'b0; // RULE11
        end
        st_nxt.hyp[n] = pwdata[`CTRL_HYP_MSB:`CTRL_HYP_LSB]; // RULE7
        st_nxt.hyn[n] = pwdata[`CTRL_HYN_MSB:`CTRL_HYN_LSB]; // RULE7
      end

      if (wr && idx == MODE_IDX[n])
      begin
        st_nxt.rie[n] = pwdata[`MODE_RIE_BIT]; // RULE16
        st_nxt.fie[n] = pwdata[`MODE_FIE_BIT]; // RULE16
        st_nxt.md[n] = pwdata[`MODE_MD_MSB:`MODE_MD_LSB]; // RULE17
      end

      if (wr && idx == MUX_IDX[n])
      begin
        st_nxt.nsel[n] = pwdata[`MUX_NEG_MSB:`MUX_NEG_LSB]; // RULE18
        st_nxt.psel[n] = pwdata[`MUX_POS_MSB:`MUX_POS_LSB]; // RULE18
      end

      // Latched output uses the enable being written, so disabling drops it at the same edge.
      st_nxt.latched[n] = st_r.sync2[n] && st_nxt.en[n]; // RULE2 RULE5
      rise[n] = st_nxt.latched[n] && !st_r.latched[n]; // RULE10
      fall[n] = !st_nxt.latched[n] && st_r.latched[n]; // RULE10

      // The status view clears a flag by writing one to it.
      if (wr && idx == `CMP_STAT_IDX)
      begin
        if (pwdata[2*n])
        begin
          st_nxt.rif[n] = 1'b0;
        end
        if (pwdata[2*n+1])
        begin
          st_nxt.fif[n] = 1'b0;
        end
      end

      // An edge in the clearing cycle keeps its flag set.
      st_nxt.rif[n] = st_nxt.rif[n] || rise[n]; // RULE10 RULE11
      st_nxt.fif[n] = st_nxt.fif[n] || fall[n]; // RULE10 RULE11

      if (idx == CTRL_IDX[n])
      begin
        rd_val = {st_r.en[n], st_r.latched[n], st_r.rif[n], st_r.fif[n],
                  st_r.hyp[n], st_r.hyn[n]}; // RULE13 RULE15
      end
      if (idx == MODE_IDX[n])
      begin
        rd_val = {2'h0, st_r.rie[n], st_r.fie[n], 2'h0, st_r.md[n]};
      end
      if (idx == MUX_IDX[n])
      begin
        rd_val = {1'b0, st_r.nsel[n], 1'b0, st_r.psel[n]}; // RULE18
      end
    end

    if (wr && idx == `CMP_MASK_IDX)
    begin
      st_nxt.mask = pwdata[3:0];
    end
    if (wr && idx == `CMP_RSRC_IDX)
    begin
      st_nxt.rst_en = pwdata[0];
    end
    if (idx == `CMP_STAT_IDX)
    begin
      rd_val = {4'h0, st_r.fif[1], st_r.rif[1], st_r.fif[0], st_r.rif[0]};
    end
    if (idx == `CMP_MASK_IDX)
    begin
      rd_val = {4'h0, st_r.mask};
    end
    if (idx == `CMP_RSRC_IDX)
    begin
      rd_val = {7'h00, st_r.rst_en};
    end

    if (psel && !penable)
    begin
      st_nxt.prdata = hit ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_RST; // RULE15 RULE17
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Configuration handed to the analog core.
  always_comb
  begin
    for (int n = 0; n < 2; n++)
    begin
      cmp_cfg[n].enable = st_r.en[n];
      cmp_cfg[n].pos_hyst = hyst_decode(st_r.hyp[n]); // RULE8
      cmp_cfg[n].neg_hyst = hyst_decode(st_r.hyn[n]); // RULE9
      cmp_cfg[n].resp_mode = st_r.md[n]; // RULE6
      cmp_cfg[n].pos_sel = st_r.psel[n]; // RULE4
      cmp_cfg[n].neg_sel = st_r.nsel[n]; // RULE4
    end
  end

  // The raw path is a plain gate so it follows the core with no clock.
  assign raw_out = cmp_raw_in & st_r.en; // RULE3 RULE5
  assign latched_out = st_r.latched; // RULE2

  // Flag, per-edge enable and mask must all be set for a request.
  assign irq = |({st_r.fif[1], st_r.rif[1], st_r.fif[0], st_r.rif[0]}
                 & {st_r.fie[1], st_r.rie[1], st_r.fie[0], st_r.rie[0]}
                 & st_r.mask); // RULE12 RULE16

  // Only comparator 0 may ask for a reset, while its result is low.
  assign reset_req = st_r.rst_en && st_r.en[0] && !st_r.latched[0]; // RULE1

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rise0;
    st_r.en[0] && $rose(cmp_raw_in[0]);
  endsequence

  sequence s_hold0;
    (st_r.en[0] && cmp_raw_in[0]) [*2];
  endsequence

  sequence s_wr_ctrl0;
    psel && penable && pwrite && paddr == ADDR_W'({`CMP_CTRL0_IDX, 2'h0});
  endsequence

  sequence s_wr_mode0;
    psel && penable && pwrite && paddr == ADDR_W'({`CMP_MODE0_IDX, 2'h0});
  endsequence

  sequence s_wr_mux0;
    psel && penable && pwrite && paddr == ADDR_W'({`CMP_MUX0_IDX, 2'h0});
  endsequence

  sequence s_low3_0;
    (!cmp_raw_in[0]) [*3];
  endsequence

  sequence s_low3_1;
    (!cmp_raw_in[1]) [*3];
  endsequence

  AST_RAW_OFF: assert property (!st_r.en[1] |-> !raw_out[1]) // RULE5
    else $error("raw output high while comparator disabled");

  AST_RAW_FOLLOW: assert property ( // RULE3
    st_r.en[0] |-> raw_out[0] == cmp_raw_in[0])
    else $error("raw output does not follow comparator");

  AST_SYNC_LAT: assert property (s_rise0 ##1 s_hold0 |=> latched_out[0] || !st_r.en[0]) // RULE19
    else $error("latched output late after input rise");

  AST_RISE_FLAG: assert property ($rose(latched_out[0]) |-> st_r.rif[0]) // RULE10
    else $error("rising flag not set on rising output");

  AST_FALL_FLAG: assert property ($fell(latched_out[1]) |-> st_r.fif[1]) // RULE10
    else $error("falling flag not set on falling output");

  AST_FLAG_STICKY: assert property ( // RULE11
    st_r.rif[0] && !(psel && penable && pwrite) |=> st_r.rif[0])
    else $error("rising flag cleared without a write");

  AST_IRQ_RISE: assert property ( // RULE16
    st_r.rif[0] && st_r.rie[0] && st_r.mask[0] |-> irq)
    else $error("interrupt missing for enabled rising flag");

  AST_IRQ_NONE: assert property ( // RULE12
    (st_r.rie == 2'h0 && st_r.fie == 2'h0) |-> !irq)
    else $error("interrupt with all edge enables off");

  AST_ENABLE_WR: assert property (s_wr_ctrl0 |=> // RULE14
    cmp_cfg[0].enable == $past(pwdata[`CTRL_EN_BIT]))
    else $error("enable bit not taken from write");

  AST_HYST_POS: assert property ( // RULE8
    s_wr_ctrl0 ##0 pwdata[3:2] == 2'h3 |=> cmp_cfg[0].pos_hyst == HYST_20MV)
    else $error("positive hysteresis code not decoded");

  AST_HYST_NEG: assert property ( // RULE9
    s_wr_ctrl0 ##0 pwdata[1:0] == 2'h1 |=> cmp_cfg[0].neg_hyst == HYST_5MV)
    else $error("negative hysteresis code not decoded");

  AST_RESULT_RD: assert property ( // RULE13
    psel && !penable && paddr == ADDR_W'({`CMP_CTRL0_IDX, 2'h0})
    |=> prdata[`CTRL_OUT_BIT] == $past(latched_out[0]))
    else $error("result bit read back wrong");

  AST_LAT_OFF0: assert property (!st_r.en[0] |-> !latched_out[0]) // RULE5
    else $error("latched output 0 high while disabled");

  AST_LAT_OFF1: assert property (!st_r.en[1] |-> !latched_out[1]) // RULE5
    else $error("latched output 1 high while disabled");

  AST_RAW_OFF0: assert property (!st_r.en[0] |-> !raw_out[0]) // RULE5
    else $error("raw output 0 high while disabled");

  AST_RAW_FOLLOW1: assert property ( // RULE3
    st_r.en[1] |-> raw_out[1] == cmp_raw_in[1])
    else $error("raw output 1 does not follow comparator");

  AST_LOW_HOLD0: assert property (s_low3_0 |=> !latched_out[0]) // RULE19
    else $error("latched output 0 high after three low samples");

  AST_LOW_HOLD1: assert property (s_low3_1 |=> !latched_out[1]) // RULE19
    else $error("latched output 1 high after three low samples");

  AST_NO_EARLY0: assert property ( // RULE19
    $rose(latched_out[0]) |-> $past(cmp_raw_in[0], 3))
    else $error("latched output 0 rose before the synchroniser delay");

  AST_NO_EARLY1: assert property ( // RULE19
    $rose(latched_out[1]) |-> $past(cmp_raw_in[1], 3))
    else $error("latched output 1 rose before the synchroniser delay");

  AST_FALL_FLAG0: assert property ($fell(latched_out[0]) |-> st_r.fif[0]) // RULE10
    else $error("falling flag 0 not set on falling output");

  AST_RISE_FLAG1: assert property ($rose(latched_out[1]) |-> st_r.rif[1]) // RULE10
    else $error("rising flag 1 not set on rising output");

  AST_RIF_CAUSE: assert property ( // RULE10
    !st_r.rif[0] ##1 st_r.rif[0] |-> $rose(latched_out[0]))
    else $error("rising flag set without a rising output");

  AST_FIF_STICKY: assert property ( // RULE11
    st_r.fif[0] && !(psel && penable && pwrite) |=> st_r.fif[0])
    else $error("falling flag cleared without a write");

  AST_IRQ_FALL: assert property ( // RULE16
    st_r.fif[0] && st_r.fie[0] && st_r.mask[1] |-> irq)
    else $error("interrupt missing for enabled falling flag");

  AST_IRQ_MASKED: assert property (st_r.mask == 4'h0 |-> !irq) // RULE12
    else $error("interrupt with every source masked");

  AST_MODE_WR: assert property (s_wr_mode0 |=> // RULE17
    cmp_cfg[0].resp_mode == $past(pwdata[`MODE_MD_MSB:`MODE_MD_LSB]))
    else $error("response mode not taken from write");

  AST_MUX_WR: assert property (s_wr_mux0 |=> // RULE4
    cmp_cfg[0].pos_sel == $past(pwdata[`MUX_POS_MSB:`MUX_POS_LSB])
    && cmp_cfg[0].neg_sel == $past(pwdata[`MUX_NEG_MSB:`MUX_NEG_LSB]))
    else $error("input selects not taken from write");

  AST_RESET_REQ: assert property ( // RULE1
    reset_req |-> st_r.en[0] && !latched_out[0])
    else $error("reset request without comparator 0 enabled and low");

  AST_RD_ZERO: assert property ( // RULE18
    psel && !penable |=> prdata[31:8] == 24'h000000)
    else $error("unused read data bits not zero");

endmodule

// >>> rtl/cmp_defs.svh
// Register indexes, field positions and reset values of the comparator block.
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

// Register indexes; the byte address is four times the index.
`define CMP_CTRL0_IDX 8'h9B
`define CMP_CTRL1_IDX 8'h9A
`define CMP_MODE0_IDX 8'h9D
`define CMP_MODE1_IDX 8'h9C
`define CMP_MUX0_IDX 8'h9F
`define CMP_MUX1_IDX 8'h9E
`define CMP_STAT_IDX 8'hA0
`define CMP_MASK_IDX 8'hA1
`define CMP_RSRC_IDX 8'hA2

// Control register fields.
`define CTRL_EN_BIT 7
`define CTRL_OUT_BIT 6
`define CTRL_RIF_BIT 5
`define CTRL_FIF_BIT 4
`define CTRL_HYP_MSB 3
`define CTRL_HYP_LSB 2
`define CTRL_HYN_MSB 1
`define CTRL_HYN_LSB 0

// Mode register fields.
`define MODE_RIE_BIT 5
`define MODE_FIE_BIT 4
`define MODE_MD_MSB 1
`define MODE_MD_LSB 0

// Input select register fields.
`define MUX_NEG_MSB 6
`define MUX_NEG_LSB 4
`define MUX_POS_MSB 2
`define MUX_POS_LSB 0

// Reset values.
`define CMP_CTRL_RST 8'h00
`define CMP_MODE_RST 8'h02
`define CMP_MD_RST 2'h2
`define CMP_MUX_RST 8'h00
`define IRQ_MASK_RST 4'h0

`endif

// >>> rtl/cmp_pkg.sv
// Types shared by the comparator control block.
package cmp_pkg;

  typedef enum logic [1:0] {HYST_OFF, HYST_5MV, HYST_10MV, HYST_20MV} hyst_e;

  typedef struct packed {
    logic enable;
    hyst_e pos_hyst;
    hyst_e neg_hyst;
    logic [1:0] resp_mode;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
  } cmp_cfg_s;

  typedef struct packed {
    logic [1:0] en;
    logic [1:0] rif;
    logic [1:0] fif;
    logic [1:0][1:0] hyp;
    logic [1:0][1:0] hyn;
    logic [1:0] rie;
    logic [1:0] fie;
    logic [1:0][1:0] md;
    logic [1:0][2:0] psel;
    logic [1:0][2:0] nsel;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] latched;
    logic [3:0] mask;
    logic rst_en;
    logic [31:0] prdata;
  } st_s;

endpackage

// >>> bench/analog_core_model.sv
// Behavioural model of the two analog comparator cores.
`timescale 1ns/1ns
module analog_core_model (
  // Settings from the block.
  input cmp_pkg::cmp_cfg_s [1:0] cfg,
  // Input voltages in millivolts.
  input wire logic [1:0][11:0] plus_mv,
  input wire logic [1:0][11:0] minus_mv,
  // Raw decisions.
  output logic [1:0] decision
);
  import cmp_pkg::*;
  function automatic int hyst_mv(hyst_e h);
    return (h == HYST_OFF) ? 0 : 5 << (int'(h) - 1);
  endfunction
  initial decision = 2'b00;
  for (genvar i = 0; i < 2; i++)
  begin : g_core
    // Slower response modes settle later, up to most of a clock period.
    always @(cfg[i] or plus_mv[i] or minus_mv[i] or decision[i])
    begin
      int d;
      d = int'(plus_mv[i]) - int'(minus_mv[i]);
      decision[i] <= #(int'(cfg[i].resp_mode) * 3)
        decision[i] ? (d > -hyst_mv(cfg[i].neg_hyst)) : (d > hyst_mv(cfg[i].pos_hyst));
    end
  end
endmodule

// >>> bench/test_voltage_comparator_ctrl.sv
// Self-checking testbench of the comparator control block.
`timescale 1ns/1ns
`include "cmp_defs.svh"
module test_voltage_comparator_ctrl;
  import cmp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, reset_req, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] cmp_raw_in, raw_out, latched_out;
  cmp_cfg_s [1:0] cmp_cfg;
  logic [1:0][11:0] plus_mv, minus_mv;
  int n_errors = 0;
  int n_checks = 0;
  voltage_comparator_ctrl u_voltage_comparator_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw_in(cmp_raw_in),
    .cmp_cfg(cmp_cfg), .raw_out(raw_out), .latched_out(latched_out), .irq(irq),
    .reset_req(reset_req));
  analog_core_model u_analog_core_model (.cfg(cmp_cfg), .plus_mv(plus_mv),
    .minus_mv(minus_mv), .decision(cmp_raw_in));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask
  task automatic rd(logic [7:0] idx, logic [7:0] exp, string what);
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
    chk(what, {24'h000000, exp}, q);
  endtask
  task automatic set_in(int c, logic [11:0] p, logic [11:0] m);
    @(posedge pclk);
    plus_mv[c] <= p;
    minus_mv[c] <= m;
  endtask
  task automatic t_reset();
    rd(`CMP_CTRL0_IDX, 8'h00, "ctrl0");
    rd(`CMP_MODE0_IDX, 8'h02, "mode0");
    rd(`CMP_MODE1_IDX, 8'h02, "mode1");
    rd(`CMP_MUX0_IDX, 8'h00, "mux0");
    chk("resp_mode", 32'h2, {30'h0, cmp_cfg[0].resp_mode});
    $display("t_reset done");
  endtask
  task automatic t_config();
    logic [7:0] ci[2] = '{`CMP_CTRL0_IDX, `CMP_CTRL1_IDX};
    logic [7:0] mi[2] = '{`CMP_MODE0_IDX, `CMP_MODE1_IDX};
    logic [7:0] xi[2] = '{`CMP_MUX0_IDX, `CMP_MUX1_IDX};
    for (int c = 0; c < 2; c++)
    begin
      for (int h = 0; h < 4; h++)
      begin
        wr(ci[c], 8'(h * 4 + 3 - h));
        #1;
        chk("pos_hyst", 32'(h), {30'h0, cmp_cfg[c].pos_hyst});
        chk("neg_hyst", 32'(3 - h), {30'h0, cmp_cfg[c].neg_hyst});
        rd(ci[c], 8'(h * 4 + 3 - h), "ctrl hyst");
        wr(mi[c], 8'(h));
        #1;
        chk("resp_mode", 32'(h), {30'h0, cmp_cfg[c].resp_mode});
      end
      wr(xi[c], 8'hCB);
      rd(xi[c], 8'h43, "mux");
      chk("pos_sel", 32'h3, {29'h0, cmp_cfg[c].pos_sel});
      chk("neg_sel", 32'h4, {29'h0, cmp_cfg[c].neg_sel});
    end
    $display("t_config done");
  endtask
  task automatic t_disable();
    set_in(0, 12'h064, 12'h032);
    repeat (3) @(posedge pclk);
    #1;
    chk("raw_out off", 32'h0, {31'h0, raw_out[0]});
    chk("latched off", 32'h0, {31'h0, latched_out[0]});
    rd(`CMP_CTRL0_IDX, 8'h0C, "ctrl0 off");
    wr(`CMP_CTRL0_IDX, 8'h80);
    #1;
    chk("raw_out on", 32'h1, {31'h0, raw_out[0]});
    set_in(0, 12'h032, 12'h064);
    repeat (3) @(posedge pclk);
    wr(`CMP_CTRL0_IDX, 8'h80);
    rd(`CMP_CTRL0_IDX, 8'h80, "ctrl0 clear");
    $display("t_disable done");
  endtask
  task automatic t_edges();
    wr(`CMP_MODE0_IDX, 8'h30);
    wr(`CMP_MASK_IDX, 8'h00);
    set_in(0, 12'h050, 12'h028);
    #1;
    chk("raw_out", 32'h1, {31'h0, raw_out[0]});
    for (int k = 0; k < 3; k++)
    begin
      @(posedge pclk);
      #1;
      chk("latched", 32'(k == 2), {31'h0, latched_out[0]});
    end
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(`CMP_CTRL0_IDX, 8'hE0, "ctrl0 rise");
    wr(`CMP_MASK_IDX, 8'h01);
    #1;
    chk("irq rise", 32'h1, {31'h0, irq});
    wr(`CMP_MODE0_IDX, 8'h10);
    #1;
    chk("irq rie off", 32'h0, {31'h0, irq});
    rd(`CMP_STAT_IDX, 8'h01, "stat sticky");
    wr(`CMP_CTRL0_IDX, 8'h90);
    rd(`CMP_CTRL0_IDX, 8'hC0, "ctrl0 rif clr");
    set_in(0, 12'h028, 12'h050);
    repeat (3) @(posedge pclk);
    rd(`CMP_CTRL0_IDX, 8'h90, "ctrl0 fall");
    wr(`CMP_MASK_IDX, 8'h02);
    #1;
    chk("irq fall", 32'h1, {31'h0, irq});
    wr(`CMP_STAT_IDX, 8'h02);
    rd(`CMP_CTRL0_IDX, 8'h80, "ctrl0 fif clr");
    chk("irq clr", 32'h0, {31'h0, irq});
    $display("t_edges done");
  endtask
  task automatic t_misc();
    wr(`CMP_CTRL1_IDX, 8'h80);
    set_in(1, 12'h064, 12'h032);
    repeat (3) @(posedge pclk);
    #1;
    chk("latched1", 32'h1, {31'h0, latched_out[1]});
    chk("raw_out1", 32'h1, {31'h0, raw_out[1]});
    set_in(1, 12'h032, 12'h064);
    repeat (3) @(posedge pclk);
    rd(`CMP_STAT_IDX, 8'h0C, "stat cmp1");
    wr(`CMP_RSRC_IDX, 8'h01);
    #1;
    chk("reset_req", 32'h1, {31'h0, reset_req});
    wr(`CMP_CTRL0_IDX, 8'h00);
    #1;
    chk("reset_req cmp1", 32'h0, {31'h0, reset_req});
    apb(1'b0, 12'h040, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, {2'b00, `CMP_MASK_IDX, 2'b01}, 8'hFF);
    chk("misaligned err", 32'h1, {31'h0, e});
    rd(`CMP_MASK_IDX, 8'h02, "mask kept");
    $display("t_misc done");
  endtask
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    plus_mv = '0;
    minus_mv = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_config();
    t_disable();
    t_edges();
    t_misc();
    complete_run();
  end
endmodule
